// [dv/tpc_enc_model.sv]
`timescale 1ns/1ps
`default_nettype none
module tpc_enc_model (
    input  wire logic       clk,
    input  wire logic       step,
    input  wire logic       up,
    output logic      [1:0] ab
);
    logic [1:0] pos = 2'h0;
    // One edge per strobe, strobes spaced four cycles apart
    always_ff @(posedge clk) begin
        if (step) begin
            pos <= up ? pos + 2'h1 : pos - 2'h1;
        end
    end
    // Gray order: bit 0 phase A, bit 1 phase B
    assign ab = {pos[1], pos[1] ^ pos[0]};
endmodule
`default_nettype wire

// [dv/tpc_timer_unit_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin mismatches++; $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module timer_pwm_phase_count_unit_tb_top;
    logic        sys_clk = 1'b0;
    logic        rst_b   = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h00000000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [2:0]  irq_req;
    logic [8:0]  irq_src;
    logic [1:0]  stp     = 2'h0;
    logic        up      = 1'b1;
    logic [31:0] q;
    wire  [3:0]  enc;
    logic [7:0]  pin_i   = 8'h00;
    logic [3:0]  dma_ack = 4'h0;
    logic [7:0]  pin_o;
    logic [7:0]  pin_oe;
    logic [3:0]  dma_req;
    int          hi;
    int          mismatches  = 0;
    int          checks_done = 0;

    tpc_timer_unit dut (.SYS_CLK(sys_clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .CMP_PIN_I(pin_i), .CMP_PIN_O(pin_o), .CMP_PIN_OE(pin_oe),
        .EXT_CLOCK_IN(enc), .DMA_ACK(dma_ack), .DMA_REQ(dma_req), .IRQ_REQ(irq_req),
        .IRQ_SRC(irq_src));
    tpc_enc_model enc1 (.clk(sys_clk), .step(stp[0]), .up(up), .ab(enc[1:0]));
    tpc_enc_model enc2 (.clk(sys_clk), .step(stp[1]), .up(up), .ab(enc[3:2]));

    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end

    // ----------------------------------------
    // Bus and stimulus tasks
    // ----------------------------------------
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        if (n >= 20) begin
            mismatches++;
            $display("[ERR] pready expected 1 seen 0");
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h00000000);
        `CHK(nm, e, q)
    endtask

    task automatic step(input int k, input logic [1:0] m, input logic u);
        repeat (k) begin
            @(posedge sys_clk);
            stp <= m;
            up  <= u;
            @(posedge sys_clk);
            stp <= 2'h0;
            repeat (2) @(posedge sys_clk);
        end
        repeat (4) @(posedge sys_clk);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge sys_clk);
        rst_b <= 1'b1;
        rd("ch0 gen a", 8'h14, 32'h0000FFFF);
        rd("ch1 status", 8'h4C, 32'h00000040);
        $display("test reset done");
        apb(1'b1, 8'h40, 32'h00000048);
        apb(1'b1, 8'h80, 32'h00000088);
        step(8, 2'h3, 1'b1);
        rd("ch1 count", 8'h50, 32'h00000008);
        rd("ch2 count", 8'h90, 32'h00000002);
        rd("ch1 status", 8'h4C, 32'h00000040);
        $display("test phase count done");
        apb(1'b1, 8'h48, 32'h00000020);
        step(9, 2'h1, 1'b0);
        rd("ch1 count", 8'h50, 32'h0000FFFF);
        rd("ch1 status", 8'h4C, 32'h00000020);
        `CHK("ch1 irq", 1'b1, irq_req[1])
        `CHK("ch1 irq src", 3'h5, irq_src[5:3])
        apb(1'b1, 8'h4C, 32'h00000000);
        repeat (2) @(posedge sys_clk);
        rd("ch1 status", 8'h4C, 32'h00000000);
        `CHK("ch1 irq", 1'b0, irq_req[1])
        $display("test underflow done");
        apb(1'b1, 8'h50, 32'h0000FFFF);
        step(1, 2'h1, 1'b1);
        rd("ch1 count", 8'h50, 32'h00000000);
        rd("ch1 status", 8'h4C, 32'h00000053);
        $display("test overflow done");
        apb(1'b1, 8'h04, 32'h00000016);
        apb(1'b1, 8'h14, 32'h00000004);
        apb(1'b1, 8'h18, 32'h00000002);
        apb(1'b1, 8'h1C, 32'h00000006);
        `CHK("ch0 pin a idle", 1'b1, pin_o[0])
        apb(1'b1, 8'h00, 32'h00000459);
        repeat (20) @(posedge sys_clk);
        hi = 0;
        repeat (14) @(posedge sys_clk) if (pin_o[0]) hi++;
        `CHK("ch0 pwm high cycles", 6, hi)
        `CHK("ch0 pin drive", 2'h1, pin_oe[1:0])
        `CHK("ch0 match req", 2'h3, dma_req[1:0])
        rd("ch0 gen a", 8'h14, 32'h00000006);
        apb(1'b1, 8'h00, 32'h00000451);
        @(posedge sys_clk) dma_ack <= 4'h1;
        @(posedge sys_clk) dma_ack <= 4'h0;
        repeat (2) @(posedge sys_clk);
        `CHK("ch0 dma clear", 2'h2, dma_req[1:0])
        `CHK("ch0 pin a stop", 1'b1, pin_o[0])
        $display("test pwm done");
        apb(1'b1, 8'h14, 32'h00000033);
        apb(1'b1, 8'h04, 32'h00000009);
        apb(1'b1, 8'h00, 32'h00000408);
        @(posedge sys_clk) pin_i <= 8'h01;
        repeat (3) @(posedge sys_clk);
        rd("ch0 buffer c", 8'h1C, 32'h00000033);
        `CHK("ch0 capture req", 1'b1, dma_req[0])
        $display("test buffer done");
        apb(1'b1, 8'h80, 32'h00000108);
        step(4, 2'h2, 1'b1);
        rd("ch2 count", 8'h90, 32'h00000004);
        apb(1'b1, 8'h80, 32'h000000C8);
        step(4, 2'h2, 1'b0);
        rd("ch2 count", 8'h90, 32'h00000003);
        $display("test phase modes done");
        rd("unmapped", 8'hC0, 32'h00000000);
        `CHK("pslverr", 1'b1, pslverr)
        $display("test unmapped done");
        tally_and_finish();
    end

    initial begin
        repeat (5000) @(posedge sys_clk);
        mismatches++;
        tally_and_finish();
    end
endmodule
`default_nettype wire

// [include/tpc_map.svh]
`ifndef TPC_MAP_SVH
`define TPC_MAP_SVH

// ----------------------------------------
// Register index (byte = ch*0x40 + idx*4)
// ----------------------------------------
`define TPC_IDX_CTRL 4'h0
`define TPC_IDX_IOC  4'h1
`define TPC_IDX_IER  4'h2
`define TPC_IDX_STAT 4'h3
`define TPC_IDX_CNT  4'h4
`define TPC_IDX_GRA  4'h5
`define TPC_IDX_GRB  4'h6
`define TPC_IDX_GRD  4'h8
`define TPC_CH_NONE  2'h3

// ----------------------------------------
// Control fields
// ----------------------------------------
`define TPC_CTL_CLR  2:0
`define TPC_CTL_RUN  3
`define TPC_CTL_PWM  5:4
`define TPC_CTL_PHS  8:6
`define TPC_CTL_SYNC 9
`define TPC_CLR_SYNC 3'h5
`define TPC_PHS_OFF  3'h0

// ----------------------------------------
// Output control nibble, status and buffer enable bits
// ----------------------------------------
`define TPC_IOC_INIT 2
`define TPC_IOC_CAP  3
`define TPC_ST_OVF   4
`define TPC_ST_UNF   5
`define TPC_BUF_A    10

// ----------------------------------------
// Reset values and counter maximum
// ----------------------------------------
`define TPC_CTRL_RST 12'h000
`define TPC_IOC_RST  16'h0000
`define TPC_CNT_RST  16'h0000
`define TPC_GR_RST   16'hFFFF
`define TPC_CNT_MAX  16'hFFFF

`endif

// [include/tpc_pkg.sv]
`default_nettype none
package tpc_pkg;
    typedef logic [15:0] tpc_word_t;
    typedef enum logic [1:0] {TPC_ACT_NONE, TPC_ACT_LOW, TPC_ACT_HIGH, TPC_ACT_TGL} tpc_act_e;
    typedef enum logic [1:0] {TPC_MODE_NORMAL, TPC_MODE_PWM1, TPC_MODE_PWM2,
                              TPC_MODE_RSVD} tpc_pwm_e;
endpackage
`default_nettype wire

// [rtl/tpc_phase_dec.sv]
`timescale 1ns/1ps
`default_nettype none
module tpc_phase_dec (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       pha,
    input  wire logic       phb,
    input  wire logic [2:0] mode,
    output logic            up,
    output logic            dn
);
    logic pa_reg;
    logic pb_reg;
    logic ar, af, br, bf;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pa_reg <= 1'b0;
            pb_reg <= 1'b0;
        end else begin
            pa_reg <= pha;
            pb_reg <= phb;
        end
    end

    always_comb begin
        ar = pha & ~pa_reg;
        af = ~pha & pa_reg;
        br = phb & ~pb_reg;
        bf = ~phb & pb_reg;
        up = 1'b0;
        dn = 1'b0;
        case (mode)
            3'h1: begin
                up = (br & pha) | (bf & ~pha) | (ar & ~phb) | (af & phb);
                dn = (br & ~pha) | (bf & pha) | (ar & phb) | (af & ~phb);
            end
            3'h2: begin
                up = af & phb;
                dn = af & ~phb;
            end
            3'h3: begin
                up = af & phb;
                dn = bf & pha;
            end
            3'h4: begin
                up = (br & pha) | (bf & ~pha);
                dn = (bf & pha) | (br & ~pha);
            end
            default: begin
                up = 1'b0;
                dn = 1'b0;
            end
        endcase
    end

    chk_mode4_a_ignored: assert property (
        @(posedge clk) disable iff (!rst_b)
        (mode == 3'h4) && (phb == pb_reg) |-> !up && !dn)
        else $error("mode 4 counted without a B edge");
    chk_mode2_up: assert property (
        @(posedge clk) disable iff (!rst_b)
        (mode == 3'h2) && !pha && $past(pha) && phb && $stable(phb) |-> up)
        else $error("mode 2 missed up count");
endmodule
`default_nettype wire

// [rtl/tpc_pin_out.sv]
`timescale 1ns/1ps
`default_nettype none
module tpc_pin_out (
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic              init_load,
    input  wire logic              init_val,
    input  wire logic              hit,
    input  wire tpc_pkg::tpc_act_e act,
    input  wire logic              oe_in,
    output logic                   level,
    output logic                   oe
);
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            level <= 1'b0;
        end else if (init_load) begin
            level <= init_val;
        end else if (hit) begin
            case (act)
                tpc_pkg::TPC_ACT_LOW:  level <= 1'b0;
                tpc_pkg::TPC_ACT_HIGH: level <= 1'b1;
                tpc_pkg::TPC_ACT_TGL:  level <= ~level;
                default:               level <= level;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            oe <= 1'b0;
        end else begin
            oe <= oe_in;
        end
    end

    chk_init_level: assert property (
        @(posedge clk) disable iff (!rst_b)
        init_load |=> level == $past(init_val))
        else $error("pin did not take its initial level");
    chk_toggle_act: assert property (
        @(posedge clk) disable iff (!rst_b)
        hit && !init_load && act == tpc_pkg::TPC_ACT_TGL |=> level != $past(level))
        else $error("toggle action did not toggle");
endmodule
`default_nettype wire

// [rtl/tpc_timer_unit.sv]
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "tpc_map.svh"

// Contract
// - Channel 0 compare match loads A/B from paired buffer
// - Buffered capture shifts old value to buffer
// - Compare match drives pin low/high/toggle
// - Clear-source register sets period; per-channel
// - PWM1 pairs A-B, C-D on A/C pins
// - PWM1 pin starts at A/C initial level
// - PWM1 equal pair values: no change
// - PWM2 cycle clear restores initial levels
// - PWM2 duty equal cycle: no change
// - PWM2 period register has no output
// - Phase counting only on channels 1, 2
// - Phase mode ignores prescaler, rest works
// - Overflow up sets flag; underflow down sets
// - Readable count direction status flag
// - Ch1 uses clocks 0,1; ch2 2,3
// - Mode 1 counts every edge both inputs
// - Mode 2 counts on A falling only
// - Mode 3 up A-fall, down B-fall
// - Mode 4 counts B edges only
// - Flags sticky; enable gates request (gates IRQ_REQ only; DMA_REQ follows the channel 0 flags ungated)
// - Fixed priority within a channel
// - Clear flag by read 1, write 0; DMA
// - Overflow wraps all ones to zero
module tpc_timer_unit (
    input  wire logic        SYS_CLK,
    input  wire logic        RST_B,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic [7:0]  CMP_PIN_I,
    output logic      [7:0]  CMP_PIN_O,
    output logic      [7:0]  CMP_PIN_OE,
    input  wire logic [3:0]  EXT_CLOCK_IN,
    input  wire logic [3:0]  DMA_ACK,
    output logic      [3:0]  DMA_REQ,
    output logic      [2:0]  IRQ_REQ,
    output logic      [8:0]  IRQ_SRC
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [11:0]       ctrl_reg [3];
    logic [15:0]       ioc_reg  [3];
    logic [5:0]        ier_reg  [3];
    logic [5:0]        flag_reg [3];
    logic [5:0]        seen_reg [3];
    logic              dir_reg  [3];
    tpc_pkg::tpc_word_t cnt_reg [3];
    tpc_pkg::tpc_word_t gr_reg  [3][4];
    logic [2:0]        src_reg  [3];
    logic [7:0]        pin_prev_reg;
    logic [31:0]       prdata_reg;
    logic              pready_reg;
    logic              pslverr_reg;
    logic [2:0]        irq_reg;

    logic              run     [3];
    logic              phs_on  [3];
    logic              t_up    [3];
    logic              t_dn    [3];
    logic              clr_own [3];
    logic              clr     [3];
    logic              dec_up  [3];
    logic              dec_dn  [3];
    logic [3:0]        match   [3];
    logic [3:0]        capt    [3];
    logic [3:0]        is_cap  [3];
    logic [5:0]        flag_set [3];
    logic              sync_src;
    logic [7:0]        pin_hit;
    logic [7:0]        pin_init;
    logic [7:0]        pin_load;
    logic [7:0]        pin_drive;
    logic [1:0]        pin_act [8];
    logic [7:0]        pin_lvl;
    logic [7:0]        pin_oe;
    logic [31:0]       rdata;
    logic              mapped;
    logic              acc;
    logic              wr;
    logic              rd;
    logic [1:0]        ach;
    logic [3:0]        aidx;

    function automatic logic ex(int c, int r);
        return (c == 0) || (r < 2);
    endfunction
    function automatic int pch(int p);
        return (p < 4) ? 0 : ((p < 6) ? 1 : 2);
    endfunction
    function automatic int prg(int p);
        return (p < 4) ? p : (p % 2);
    endfunction
    function automatic logic hit_wr(logic w, logic [1:0] ch, logic [3:0] ix, int c, int i);
        return w && (ch == 2'(c)) && (ix == 4'(i));
    endfunction

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    assign ach  = PADDR[7:6];
    assign aidx = PADDR[5:2];
    assign acc  = PSEL && PENABLE && pready_reg;
    assign wr   = acc && PWRITE && mapped;
    assign rd   = acc && !PWRITE && mapped;
    assign mapped = (ach != `TPC_CH_NONE) &&
                    ((aidx <= `TPC_IDX_GRB) || ((ach == 2'h0) && (aidx <= `TPC_IDX_GRD)));

    always_comb begin
        rdata = 32'h0000_0000;
        if (mapped) begin
            case (aidx)
                `TPC_IDX_CTRL: rdata[11:0] = ctrl_reg[ach];
                `TPC_IDX_IOC:  rdata[15:0] = ioc_reg[ach];
                `TPC_IDX_IER:  rdata[5:0]  = ier_reg[ach];
                `TPC_IDX_STAT: rdata[6:0]  = {dir_reg[ach], flag_reg[ach]};
                `TPC_IDX_CNT:  rdata[15:0] = cnt_reg[ach];
                default:       rdata[15:0] = gr_reg[ach][2'(aidx - `TPC_IDX_GRA)];
            endcase
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
        end else begin
            pready_reg <= PSEL && !PENABLE;
            if (PSEL && !PENABLE) begin
                pslverr_reg <= !mapped;
                prdata_reg  <= PWRITE ? 32'h0000_0000 : rdata;
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        for (int c = 0; c < 3; c++) begin
            if (!RST_B) begin
                ctrl_reg[c] <= `TPC_CTRL_RST;
                ioc_reg[c]  <= `TPC_IOC_RST;
                ier_reg[c]  <= 6'h00;
            end else begin
                if (hit_wr(wr, ach, aidx, c, `TPC_IDX_CTRL))
                    ctrl_reg[c] <= PWDATA[11:0];
                if (hit_wr(wr, ach, aidx, c, `TPC_IDX_IOC))
                    ioc_reg[c] <= PWDATA[15:0];
                if (hit_wr(wr, ach, aidx, c, `TPC_IDX_IER))
                    ier_reg[c] <= PWDATA[5:0];
            end
        end
    end

    // ----------------------------------------
    // Two-phase decoders
    // ----------------------------------------
    assign dec_up[0] = 1'b0;
    assign dec_dn[0] = 1'b0;
    for (genvar g = 1; g < 3; g++) begin : g_dec
        tpc_phase_dec u_dec (
            .clk  (SYS_CLK),
            .rst_b(RST_B),
            .pha  (EXT_CLOCK_IN[2*g-2]),
            .phb  (EXT_CLOCK_IN[2*g-1]),
            .mode (ctrl_reg[g][`TPC_CTL_PHS]),
            .up   (dec_up[g]),
            .dn   (dec_dn[g])
        );
    end

    // ----------------------------------------
    // Counting, match, capture, clear
    // ----------------------------------------
    always_comb begin
        sync_src = 1'b0;
        for (int c = 0; c < 3; c++) begin
            capt[c]   = 4'h0;
            is_cap[c] = 4'h0;
            match[c]  = 4'h0;
        end
        for (int p = 0; p < 8; p++) begin
            is_cap[pch(p)][prg(p)] = ioc_reg[pch(p)][4*prg(p)+`TPC_IOC_CAP];
            capt[pch(p)][prg(p)] = is_cap[pch(p)][prg(p)] &&
                ((ioc_reg[pch(p)][4*prg(p)] && CMP_PIN_I[p] && !pin_prev_reg[p]) ||
                 (ioc_reg[pch(p)][4*prg(p)+1] && !CMP_PIN_I[p] && pin_prev_reg[p]));
        end
        for (int c = 0; c < 3; c++) begin
            run[c]    = ctrl_reg[c][`TPC_CTL_RUN];
            phs_on[c] = (c != 0) && (ctrl_reg[c][`TPC_CTL_PHS] != `TPC_PHS_OFF);
            t_up[c]   = run[c] && (phs_on[c] ? dec_up[c] : 1'b1);
            t_dn[c]   = run[c] && phs_on[c] && dec_dn[c];
            clr_own[c] = 1'b0;
            for (int r = 0; r < 4; r++) begin
                match[c][r] = ex(c, r) && !is_cap[c][r] && (t_up[c] || t_dn[c]) &&
                              (cnt_reg[c] == gr_reg[c][r]);
                if (ctrl_reg[c][`TPC_CTL_CLR] == 3'(r + 1))
                    clr_own[c] = match[c][r] || capt[c][r];
            end
            if (ctrl_reg[c][`TPC_CTL_SYNC] && clr_own[c])
                sync_src = 1'b1;
            flag_set[c] = {t_dn[c] && (cnt_reg[c] == 16'h0000),
                           t_up[c] && (cnt_reg[c] == `TPC_CNT_MAX), match[c] | capt[c]};
        end
        for (int c = 0; c < 3; c++) begin
            clr[c] = clr_own[c] || (ctrl_reg[c][`TPC_CTL_SYNC] && sync_src &&
                     (ctrl_reg[c][`TPC_CTL_CLR] == `TPC_CLR_SYNC));
        end
    end

    always_ff @(posedge SYS_CLK) begin
        for (int c = 0; c < 3; c++) begin
            if (!RST_B) begin
                cnt_reg[c] <= `TPC_CNT_RST;
                dir_reg[c] <= 1'b1;
            end else begin
                if (clr[c])
                    cnt_reg[c] <= `TPC_CNT_RST;
                else if (hit_wr(wr, ach, aidx, c, `TPC_IDX_CNT))
                    cnt_reg[c] <= PWDATA[15:0];
                else if (t_up[c])
                    cnt_reg[c] <= cnt_reg[c] + 16'h0001;
                else if (t_dn[c])
                    cnt_reg[c] <= cnt_reg[c] - 16'h0001;
                if (t_up[c] || t_dn[c])
                    dir_reg[c] <= t_up[c];
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        for (int c = 0; c < 3; c++) begin
            for (int r = 0; r < 4; r++) begin
                if (!RST_B)
                    gr_reg[c][r] <= `TPC_GR_RST;
                else if (capt[c][r])
                    gr_reg[c][r] <= cnt_reg[c];
                else if (ex(c, r) && hit_wr(wr, ach, aidx, c, r + 5))
                    gr_reg[c][r] <= PWDATA[15:0];
            end
        end
        for (int r = 0; r < 2; r++) begin
            if (RST_B && ctrl_reg[0][`TPC_BUF_A+r]) begin
                if (match[0][r])
                    gr_reg[0][r] <= hit_wr(wr, ach, aidx, 0, r + 7) ?
                                    PWDATA[15:0] : gr_reg[0][r+2];
                if (capt[0][r])
                    gr_reg[0][r+2] <= gr_reg[0][r];
            end
        end
    end

    // ----------------------------------------
    // Status flags and requests
    // ----------------------------------------
    always_ff @(posedge SYS_CLK) begin
        for (int c = 0; c < 3; c++) begin
            if (!RST_B) begin
                flag_reg[c] <= 6'h00;
                seen_reg[c] <= 6'h00;
            end else begin
                for (int b = 0; b < 6; b++) begin
                    if (flag_set[c][b])
                        flag_reg[c][b] <= 1'b1;
                    else if ((c == 0) && (b < 4) && DMA_ACK[b])
                        flag_reg[c][b] <= 1'b0;
                    else if (hit_wr(wr, ach, aidx, c, `TPC_IDX_STAT) &&
                             seen_reg[c][b] && !PWDATA[b])
                        flag_reg[c][b] <= 1'b0;
                end
                if (hit_wr(rd, ach, aidx, c, `TPC_IDX_STAT))
                    seen_reg[c] <= flag_reg[c];
                else if (hit_wr(wr, ach, aidx, c, `TPC_IDX_STAT))
                    seen_reg[c] <= 6'h00;
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        for (int c = 0; c < 3; c++) begin
            if (!RST_B) begin
                irq_reg[c] <= 1'b0;
                src_reg[c] <= 3'h7;
            end else begin
                irq_reg[c] <= |(flag_reg[c] & ier_reg[c]);
                src_reg[c] <= 3'h7;
                for (int b = 5; b >= 0; b--) begin
                    if (flag_reg[c][b] && ier_reg[c][b])
                        src_reg[c] <= 3'(b);
                end
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_B)
            pin_prev_reg <= 8'h00;
        else
            pin_prev_reg <= CMP_PIN_I;
    end

    // ----------------------------------------
    // Output pin control
    // ----------------------------------------
    always_comb begin
        for (int p = 0; p < 8; p++) begin
            automatic int c = pch(p);
            automatic int r = prg(p);
            automatic logic [3:0] own = ioc_reg[c][4*r +: 4];
            pin_hit[p]  = match[c][r];
            pin_act[p]  = own[1:0];
            pin_init[p] = own[`TPC_IOC_INIT];
            pin_load[p] = !run[c];
            pin_drive[p] = !is_cap[c][r];
            case (tpc_pkg::tpc_pwm_e'(ctrl_reg[c][`TPC_CTL_PWM]))
                tpc_pkg::TPC_MODE_PWM1: begin
                    pin_drive[p] = (r % 2 == 0);
                    if (r % 2 == 0) begin
                        pin_hit[p] = match[c][r] ^ match[c][r+1];
                        if (match[c][r+1])
                            pin_act[p] = ioc_reg[c][4*r+4 +: 2];
                    end
                end
                tpc_pkg::TPC_MODE_PWM2: begin
                    pin_drive[p] = !is_cap[c][r] &&
                                  (ctrl_reg[c][`TPC_CTL_CLR] != 3'(r + 1));
                    pin_load[p] = !run[c] || clr[c];
                end
                default: begin
                    pin_drive[p] = !is_cap[c][r];
                end
            endcase
        end
    end

    for (genvar p = 0; p < 8; p++) begin : g_pin
        tpc_pin_out u_pin (
            .clk      (SYS_CLK),
            .rst_b    (RST_B),
            .init_load(pin_load[p]),
            .init_val (pin_init[p]),
            .hit      (pin_hit[p]),
            .act      (tpc_pkg::tpc_act_e'(pin_act[p])),
            .oe_in    (pin_drive[p]),
            .level    (pin_lvl[p]),
            .oe       (pin_oe[p])
        );
    end

    assign CMP_PIN_O  = pin_lvl;
    assign CMP_PIN_OE = pin_oe;
    assign PRDATA     = prdata_reg;
    assign PREADY     = pready_reg;
    assign PSLVERR    = pslverr_reg;
    assign IRQ_REQ    = irq_reg;
    assign IRQ_SRC    = {src_reg[2], src_reg[1], src_reg[0]};
    assign DMA_REQ    = flag_reg[0][3:0];

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_ovf_flag: assert property (
        @(posedge SYS_CLK) disable iff (!RST_B)
        t_up[1] && cnt_reg[1] == 16'hFFFF |=> flag_reg[1][`TPC_ST_OVF])
        else $error("overflow flag not set");
    chk_unf_flag: assert property (
        @(posedge SYS_CLK) disable iff (!RST_B)
        t_dn[1] && cnt_reg[1] == 16'h0000 |=> flag_reg[1][`TPC_ST_UNF])
        else $error("underflow flag not set");
    chk_wrap_up: assert property (
        @(posedge SYS_CLK) disable iff (!RST_B)
        t_up[1] && !clr[1] && !wr && cnt_reg[1] == 16'hFFFF |=> cnt_reg[1] == 16'h0000)
        else $error("counter did not wrap to zero");
    chk_wrap_down: assert property (
        @(posedge SYS_CLK) disable iff (!RST_B)
        t_dn[1] && !clr[1] && !wr && cnt_reg[1] == 16'h0000 |=> cnt_reg[1] == 16'hFFFF)
        else $error("counter did not wrap to all ones");
    chk_buf_compare: assert property (
        @(posedge SYS_CLK) disable iff (!RST_B)
        ctrl_reg[0][`TPC_BUF_A] && match[0][0] && !wr |=> gr_reg[0][0] == $past(gr_reg[0][2]))
        else $error("buffer not copied on compare match");
    chk_buf_capture: assert property (
        @(posedge SYS_CLK) disable iff (!RST_B)
        ctrl_reg[0][`TPC_BUF_A] && capt[0][0] |=>
            gr_reg[0][2] == $past(gr_reg[0][0]) && gr_reg[0][0] == $past(cnt_reg[0]))
        else $error("buffered capture wrong");
    chk_irq_gate: assert property (
        @(posedge SYS_CLK) disable iff (!RST_B)
        ##1 IRQ_REQ[0] == $past(|(flag_reg[0] & ier_reg[0])))
        else $error("request does not follow flag and enable");
    chk_dir_flag: assert property (
        @(posedge SYS_CLK) disable iff (!RST_B)
        t_dn[1] |=> !dir_reg[1])
        else $error("direction flag not down");
    chk_ch0_no_phase: assert property (
        @(posedge SYS_CLK) disable iff (!RST_B)
        run[0] && !clr[0] && !wr |=> cnt_reg[0] == $past(cnt_reg[0]) + 16'h0001)
        else $error("channel 0 did not count up");
endmodule
`default_nettype wire
